/* File: inc/pifs_regs.svh */
`ifndef PIFS_REGS_SVH
`define PIFS_REGS_SVH

`define PIFS_OFF_FLAGS1 12'h000
`define PIFS_OFF_FLAGS2 12'h004
`define PIFS_OFF_ENABLE1 12'h008
`define PIFS_OFF_ENABLE2 12'h00c
`define PIFS_OFF_CONTROL 12'h010
`define PIFS_OFF_STATUS 12'h014

`define PIFS_FLAGS1_RESET 8'h00
`define PIFS_FLAGS2_RESET 8'h00
`define PIFS_FLAGS1_WMASK 8'hcf
`define PIFS_FLAGS2_IMPL 8'h89

`define PIFS_CTL_GIE_BIT 0
`define PIFS_CTL_PERIPHERAL_IRQ_ENABLE_BIT 1
`define PIFS_CTL_WDT_SLEEP_BIT 2
`define PIFS_CTL_WDT_EN_BIT 3
`define PIFS_CTL_EXT_EN_BIT 4

`define PIFS_ST_PD_BIT 0
`define PIFS_ST_TO_BIT 1
`define PIFS_ST_SLEEP_BIT 2

`define PIFS_VECTOR 16'h0004
`define PIFS_WDT_WIDTH 16
`define PIFS_WDT_LIMIT 16'hffff

`endif

/* File: inc/pifs_pkg.sv */
package pifs_pkg;
    typedef enum logic [1:0] {PIFS_RUN, PIFS_SLEEP, PIFS_WAKE} pifs_state_e;
    typedef logic [7:0] pifs_byte_t;
endpackage

/* File: rtl/pifs_top.sv */
`timescale 1ns/1ns
`include "pifs_regs.svh"
// Function
// - Flags set on events regardless of enables
// - Flags1 bit order timer1 gate down
// - Serial flags read-only; all reset zero
// - Flags2 bits 7,3,0; others read zero
// - Flag reads one while pending
// - Sleep entered only by sleep instruction
// - Sleep entry clears watchdog, may count
// - Sleep entry clears power-down flag
// - Sleep entry sets watchdog-expiry flag
// - Processor clock gated during sleep
// - Slow oscillators keep running in sleep
// - Converter runs on dedicated clock
// - Pins hold drive state in sleep
// - Sleep leaves non-watchdog resets alone
// - Listed events wake the device
// - Pin/brownout/power-on reset; others resume
// - Next instruction prefetched during sleep
// - Enabled interrupt wakes regardless of global
// - Global clear continues; set vectors after
// - Watchdog cleared on every wake
// - Pending enabled interrupt makes sleep no-op
// - Service routine vector at 0004h
// - Peripheral interrupts need peripheral enable
module pifs_top #(
    parameter int WDT_WIDTH = `PIFS_WDT_WIDTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] flags1_event,
    input wire logic [7:0] flags2_event,
    input wire logic ext_irq,
    input wire logic sleep_exec,
    input wire logic ext_reset_pin_n,
    input wire logic brownout_event,
    input wire logic power_on_event,
    output logic cpu_clk_en,
    output logic periph_irq_req,
    output logic irq_take,
    output logic [15:0] irq_vector,
    output logic sleep_nop,
    output logic prefetch_next,
    output logic resume_pulse,
    output logic device_reset_req,
    output logic wdt_expired,
    output logic io_hold,
    output logic slow_osc_run,
    output logic adc_rc_run
);
    // Asynchronous sources pass two stages first
    // Reset pin stages start high, its idle level, so release is no false reset
    logic [1:0] ext_irq_sy_ff, external_reset_pin_sy_ff, bor_sy_ff, por_sy_ff;
    logic [7:0] ev1_s1_ff, ev1_s2_ff, ev2_s1_ff, ev2_s2_ff;
    pifs_pkg::pifs_byte_t flags1_ff, flags2_ff, enable1_ff, enable2_ff;
    logic [4:0] control_ff;
    logic pd_n_ff, to_n_ff;
    pifs_pkg::pifs_state_e state_ff, nxt_state;
    logic [WDT_WIDTH-1:0] wdt_ff;
    logic aw_hold_ff, w_hold_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff, rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic irq_take_ff, resume_ff, nop_ff, prefetch_ff, reset_req_ff, wdt_exp_ff;
    logic global_irq_enable, peripheral_irq_enable, wdt_sleep_en, wdt_en, ext_en;
    logic [7:0] pend1, pend2;
    logic periph_pend, any_pend, wr_fire, wr1, wr2, wdt_hit, hard_evt, sleep_go;

    // Word decode only; byte lanes of one word alias to the same register
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, `PIFS_OFF_FLAGS1) || hit(a, `PIFS_OFF_FLAGS2)
            || hit(a, `PIFS_OFF_ENABLE1) || hit(a, `PIFS_OFF_ENABLE2)
            || hit(a, `PIFS_OFF_CONTROL) || hit(a, `PIFS_OFF_STATUS);
    endfunction

    assign global_irq_enable = control_ff[`PIFS_CTL_GIE_BIT];
    assign peripheral_irq_enable = control_ff[`PIFS_CTL_PERIPHERAL_IRQ_ENABLE_BIT];
    assign wdt_sleep_en = control_ff[`PIFS_CTL_WDT_SLEEP_BIT];
    assign wdt_en = control_ff[`PIFS_CTL_WDT_EN_BIT];
    assign ext_en = control_ff[`PIFS_CTL_EXT_EN_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_irq_sy_ff <= 2'h0;
            external_reset_pin_sy_ff <= 2'h3;
            bor_sy_ff <= 2'h0;
            por_sy_ff <= 2'h0;
            ev1_s1_ff <= 8'h00;
            ev1_s2_ff <= 8'h00;
            ev2_s1_ff <= 8'h00;
            ev2_s2_ff <= 8'h00;
        end
        else if (clk_en)
        begin
            ext_irq_sy_ff <= {ext_irq_sy_ff[0], ext_irq};
            external_reset_pin_sy_ff <= {external_reset_pin_sy_ff[0], ext_reset_pin_n};
            bor_sy_ff <= {bor_sy_ff[0], brownout_event};
            por_sy_ff <= {por_sy_ff[0], power_on_event};
            ev1_s1_ff <= flags1_event;
            ev1_s2_ff <= ev1_s1_ff;
            ev2_s1_ff <= flags2_event;
            ev2_s2_ff <= ev2_s1_ff;
        end
    end

    assign pend1 = flags1_ff & enable1_ff;
    assign pend2 = flags2_ff & enable2_ff & `PIFS_FLAGS2_IMPL;
    assign periph_pend = peripheral_irq_enable && ((|pend1) || (|pend2));
    assign any_pend = periph_pend || ext_irq_sy_ff[1];
    assign periph_irq_req = periph_pend;
    assign hard_evt = (ext_en && !external_reset_pin_sy_ff[1]) || bor_sy_ff[1] || por_sy_ff[1];

    // AXI write: address and data caught independently
    // One write in flight; the next waits until bready takes the response
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready = !w_hold_ff && !bvalid_ff;
    assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign wr1 = wr_fire && hit(awaddr_ff, `PIFS_OFF_FLAGS1) && wstrb_ff[0];
    assign wr2 = wr_fire && hit(awaddr_ff, `PIFS_OFF_FLAGS2) && wstrb_ff[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr[11:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= mapped(awaddr_ff) ? 2'h0 : 2'h2;
            end
            else if (bvalid_ff && s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // Set beats a same-cycle software clear
    // Serial flags clear only on reset here; their own units own that clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags1_ff <= `PIFS_FLAGS1_RESET;
            flags2_ff <= `PIFS_FLAGS2_RESET;
        end
        else if (clk_en)
        begin
            flags1_ff <= (wr1 ? ((flags1_ff & ~8'(`PIFS_FLAGS1_WMASK))
                | (wdata_ff[7:0] & 8'(`PIFS_FLAGS1_WMASK))) : flags1_ff)
                | ev1_s2_ff;
            flags2_ff <= ((wr2 ? wdata_ff[7:0] : flags2_ff) | ev2_s2_ff)
                & 8'(`PIFS_FLAGS2_IMPL);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable1_ff <= 8'h00;
            enable2_ff <= 8'h00;
            control_ff <= 5'h00;
        end
        else if (clk_en && wr_fire && wstrb_ff[0])
        begin
            if (hit(awaddr_ff, `PIFS_OFF_ENABLE1))
                enable1_ff <= wdata_ff[7:0];
            if (hit(awaddr_ff, `PIFS_OFF_ENABLE2))
                enable2_ff <= wdata_ff[7:0] & 8'(`PIFS_FLAGS2_IMPL);
            if (hit(awaddr_ff, `PIFS_OFF_CONTROL))
                control_ff <= wdata_ff[4:0];
        end
    end

    // AXI read
    // Reads have no side effects; writable flags clear only by a written zero
    assign s_axi_arready = !rvalid_ff;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'h0;
        end
        else if (clk_en)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                rvalid_ff <= 1'b1;
                rresp_ff <= mapped(s_axi_araddr[11:0]) ? 2'h0 : 2'h2;
                if (hit(s_axi_araddr[11:0], `PIFS_OFF_FLAGS1))
                    rdata_ff <= {24'h000000, flags1_ff};
                else if (hit(s_axi_araddr[11:0], `PIFS_OFF_FLAGS2))
                    rdata_ff <= {24'h000000, flags2_ff};
                else if (hit(s_axi_araddr[11:0], `PIFS_OFF_ENABLE1))
                    rdata_ff <= {24'h000000, enable1_ff};
                else if (hit(s_axi_araddr[11:0], `PIFS_OFF_ENABLE2))
                    rdata_ff <= {24'h000000, enable2_ff};
                else if (hit(s_axi_araddr[11:0], `PIFS_OFF_CONTROL))
                    rdata_ff <= {27'h0000000, control_ff};
                else if (hit(s_axi_araddr[11:0], `PIFS_OFF_STATUS))
                    rdata_ff <= {29'h00000000, state_ff == pifs_pkg::PIFS_SLEEP,
                        to_n_ff, pd_n_ff};
                else
                    rdata_ff <= 32'h0000_0000;
            end
            else if (rvalid_ff && s_axi_rready)
            begin
                rvalid_ff <= 1'b0;
            end
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // Sleep sequencer
    // Hard events skip WAKE: the device restarts, so no resume or service call
    assign sleep_go = sleep_exec && state_ff == pifs_pkg::PIFS_RUN && !any_pend;
    assign wdt_hit = wdt_en && (wdt_ff == WDT_WIDTH'(`PIFS_WDT_LIMIT));

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            pifs_pkg::PIFS_RUN:
                if (sleep_go)
                    nxt_state = pifs_pkg::PIFS_SLEEP;
            pifs_pkg::PIFS_SLEEP:
                if (any_pend || wdt_hit)
                    nxt_state = pifs_pkg::PIFS_WAKE;
            pifs_pkg::PIFS_WAKE:
                nxt_state = pifs_pkg::PIFS_RUN;
            default:
                nxt_state = pifs_pkg::PIFS_RUN;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_ff <= pifs_pkg::PIFS_RUN;
        else if (clk_en)
            state_ff <= hard_evt ? pifs_pkg::PIFS_RUN : nxt_state;
    end

    // Status bits are active-low pending-style flags, set to one by reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pd_n_ff <= 1'b1;
            to_n_ff <= 1'b1;
        end
        else if (clk_en)
        begin
            if (sleep_go)
            begin
                pd_n_ff <= 1'b0;
                to_n_ff <= 1'b1;
            end
            else if (state_ff == pifs_pkg::PIFS_SLEEP && wdt_hit)
                to_n_ff <= 1'b0;
        end
    end

    // Watchdog: only frozen in sleep when not enabled there
    // A hard event clears it too, since that wake restarts the device
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wdt_ff <= '0;
        else if (clk_en)
        begin
            if (sleep_go || hard_evt || state_ff == pifs_pkg::PIFS_WAKE || !wdt_en)
                wdt_ff <= '0;
            else if (state_ff != pifs_pkg::PIFS_SLEEP || wdt_sleep_en)
                wdt_ff <= wdt_ff + WDT_WIDTH'(1);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_take_ff <= 1'b0;
            resume_ff <= 1'b0;
            nop_ff <= 1'b0;
            prefetch_ff <= 1'b0;
            reset_req_ff <= 1'b0;
            wdt_exp_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            nop_ff <= sleep_exec && state_ff == pifs_pkg::PIFS_RUN && any_pend;
            prefetch_ff <= sleep_go;
            resume_ff <= state_ff == pifs_pkg::PIFS_WAKE && !hard_evt;
            irq_take_ff <= state_ff == pifs_pkg::PIFS_WAKE && global_irq_enable && any_pend
                && !hard_evt;
            reset_req_ff <= hard_evt;
            wdt_exp_ff <= state_ff == pifs_pkg::PIFS_SLEEP && wdt_hit;
        end
    end

    // Sleep outputs decode the state register; slow clocks are never gated
    assign cpu_clk_en = state_ff != pifs_pkg::PIFS_SLEEP;
    assign io_hold = state_ff == pifs_pkg::PIFS_SLEEP;
    assign slow_osc_run = 1'b1;
    assign adc_rc_run = 1'b1;
    assign irq_take = irq_take_ff;
    assign irq_vector = `PIFS_VECTOR;
    assign sleep_nop = nop_ff;
    assign prefetch_next = prefetch_ff;
    assign resume_pulse = resume_ff;
    assign device_reset_req = reset_req_ff;
    assign wdt_expired = wdt_exp_ff;
endmodule // pifs_top

/* File: test/pifs_top_properties.sv */
`timescale 1ns/1ns
module pifs_top_properties #(
    parameter int WDT_WIDTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sleep_exec,
    input wire logic ext_irq,
    input wire logic cpu_clk_en,
    input wire logic periph_irq_req,
    input wire logic irq_take,
    input wire logic [15:0] irq_vector,
    input wire logic sleep_nop,
    input wire logic prefetch_next,
    input wire logic resume_pulse,
    input wire logic io_hold,
    input wire logic slow_osc_run,
    input wire logic adc_rc_run
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence sleep_acc;
        sleep_exec && cpu_clk_en && !periph_irq_req && !$past(ext_irq, 2);
    endsequence
    sequence asleep_req;
        !cpu_clk_en && periph_irq_req;
    endsequence
    sleep_cause_a: assert property ($fell(cpu_clk_en) |-> $past(sleep_exec))
        else $error("sleep entered without sleep instruction");
    entry_steps_a: assert property (sleep_acc |=> !cpu_clk_en && prefetch_next && io_hold)
        else $error("sleep entry incomplete");
    osc_run_a: assert property (slow_osc_run && adc_rc_run)
        else $error("slow clocks stopped");
    irq_vector_a: assert property (irq_take |-> irq_vector == 16'h0004)
        else $error("wrong service vector");
    nop_cause_a: assert property (sleep_nop |-> $past(sleep_exec) && cpu_clk_en)
        else $error("no-op without sleep instruction");
    nop_pending_a: assert property (sleep_exec && cpu_clk_en && periph_irq_req |=> sleep_nop)
        else $error("sleep taken with request pending");
    irq_wake_a: assert property (asleep_req |-> ##[1:4] resume_pulse)
        else $error("no wake on enabled request");
    take_resume_a: assert property (irq_take |-> resume_pulse && cpu_clk_en)
        else $error("service call without resume");
endmodule // pifs_top_properties

bind pifs_top pifs_top_properties #(.WDT_WIDTH(WDT_WIDTH)) i_pifs_top_properties (
    .aclk, .aresetn, .sleep_exec, .ext_irq, .cpu_clk_en, .periph_irq_req, .irq_take,
    .irq_vector, .sleep_nop, .prefetch_next, .resume_pulse, .io_hold, .slow_osc_run, .adc_rc_run
);

/* File: test/pifs_core_model.sv */
`timescale 1ns/1ns
module pifs_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sleep_cmd,
    input wire logic cpu_clk_en,
    input wire logic irq_take,
    input wire logic [15:0] irq_vector,
    output logic sleep_exec,
    output logic [15:0] pc_ff
);
    logic sleep_exec_ff;
    assign sleep_exec = sleep_exec_ff;
    // Core issues sleep only while its clock runs; code keeps a no-op after it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sleep_exec_ff <= 1'b0;
        else
            sleep_exec_ff <= sleep_cmd && cpu_clk_en;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pc_ff <= 16'h0000;
        else if (irq_take)
            pc_ff <= irq_vector;
    end
endmodule // pifs_core_model

/* File: test/pifs_top_bench.sv */
`timescale 1ns/1ns
`include "pifs_regs.svh"
module pifs_top_bench;
    logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, ext_irq = 1'b0, sleep_cmd = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, nop_seen = 1'b0, wdt_seen = 1'b0;
    logic ext_reset_pin_n = 1'b1, brownout_event = 1'b0, power_on_event = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [7:0] flags1_event = 8'h00, flags2_event = 8'h00, exp1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
    logic [31:0] s_axi_rdata, rd;
    logic sleep_exec, cpu_clk_en, periph_irq_req, irq_take, sleep_nop, prefetch_next;
    logic resume_pulse, device_reset_req, wdt_expired, io_hold, slow_osc_run, adc_rc_run, took;
    logic [15:0] irq_vector, pc;
    int errors = 0, cmp_count = 0;

    always #4 aclk = ~aclk;

    pifs_top #(.WDT_WIDTH(4)) i_pifs_top (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .flags1_event, .flags2_event, .ext_irq, .sleep_exec,
        .ext_reset_pin_n, .brownout_event, .power_on_event, .cpu_clk_en, .periph_irq_req,
        .irq_take, .irq_vector, .sleep_nop, .prefetch_next, .resume_pulse,
        .device_reset_req, .wdt_expired, .io_hold, .slow_osc_run, .adc_rc_run);
    pifs_core_model i_pifs_core_model (.aclk, .aresetn, .sleep_cmd, .cpu_clk_en,
        .irq_take, .irq_vector, .sleep_exec, .pc_ff(pc));

    // Pulses are short; latch them so later reads can judge
    always @(posedge aclk)
    begin
        if (sleep_nop === 1'b1) nop_seen <= 1'b1;
        if (wdt_expired === 1'b1) wdt_seen <= 1'b1;
    end

    task print_verdict;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {20'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        bs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Events need two sync stages; return once they reach the second stage, one edge before the flags
    task pulse_ev(input logic [7:0] a, input logic [7:0] b);
        flags1_event <= a;
        flags2_event <= b;
        @(posedge aclk);
        flags1_event <= 8'h00;
        flags2_event <= 8'h00;
        @(posedge aclk);
    endtask

    task rchk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge aclk);
        s_axi_araddr <= {20'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(rd, exp);
    endtask

    task pulse_sleep;
        @(posedge aclk);
        sleep_cmd <= 1'b1;
        @(posedge aclk);
        sleep_cmd <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    task wait_wake;
        int n;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (resume_pulse === 1'b1 || device_reset_req === 1'b1) break;
        end
        took = irq_take;
        chk({31'h0, n < 100}, 32'h1);
    endtask

    task do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        print_verdict;
    end

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`PIFS_OFF_FLAGS1, 32'h0);
        rchk(`PIFS_OFF_FLAGS2, 32'h0);
        rchk(`PIFS_OFF_STATUS, 32'h3);
        rchk(12'h0fc, 32'h0);
        chk({30'h0, rs}, 32'h2);
        wr(12'h0fc, 32'h0);
        chk({30'h0, bs}, 32'h2);
        wr(`PIFS_OFF_FLAGS1, 32'hff);
        chk({30'h0, bs}, 32'h0);
        rchk(`PIFS_OFF_FLAGS1, 32'hcf);
        wr(`PIFS_OFF_FLAGS2, 32'hff);
        rchk(`PIFS_OFF_FLAGS2, 32'h89);
        wr(`PIFS_OFF_FLAGS1, 32'h0);
        wr(`PIFS_OFF_FLAGS2, 32'h0);
        rchk(`PIFS_OFF_FLAGS1, 32'h0);
        exp1 = 8'h00;
        // One source at a time, all enables off, so bit order shows
        for (int i = 0; i < 8; i++)
        begin
            pulse_ev(8'h01 << i, 8'h01 << i);
            exp1 = exp1 | (8'h01 << i);
            rchk(`PIFS_OFF_FLAGS1, {24'h0, exp1});
            rchk(`PIFS_OFF_FLAGS2, {24'h0, exp1 & 8'h89});
        end
        wr(`PIFS_OFF_FLAGS1, 32'h0);
        rchk(`PIFS_OFF_FLAGS1, 32'h30);
        do_reset;
        rchk(`PIFS_OFF_FLAGS1, 32'h0);
        wr(`PIFS_OFF_ENABLE1, 32'h01);
        pulse_ev(8'h01, 8'h00);
        rchk(`PIFS_OFF_FLAGS1, 32'h1);
        chk({31'h0, periph_irq_req}, 32'h0);
        wr(`PIFS_OFF_CONTROL, 32'h02);
        chk({31'h0, periph_irq_req}, 32'h1);
        pulse_sleep;
        chk({31'h0, nop_seen}, 32'h1);
        rchk(`PIFS_OFF_STATUS, 32'h3);
        for (int g = 0; g < 2; g++)
        begin
            wr(`PIFS_OFF_FLAGS1, 32'h0);
            wr(`PIFS_OFF_CONTROL, 32'h2 | g);
            pulse_sleep;
            rchk(`PIFS_OFF_STATUS, 32'h6);
            pulse_ev(8'h01, 8'h00);
            wait_wake;
            chk({31'h0, took}, g);
            rchk(`PIFS_OFF_STATUS, 32'h2);
        end
        chk({16'h0, pc}, 32'h4);
        wr(`PIFS_OFF_FLAGS1, 32'h0);
        wr(`PIFS_OFF_CONTROL, 32'h0c);
        pulse_sleep;
        wait_wake;
        wr(`PIFS_OFF_CONTROL, 32'h0);
        chk({31'h0, wdt_seen}, 32'h1);
        chk({30'h0, device_reset_req, took}, 32'h0);
        rchk(`PIFS_OFF_STATUS, 32'h0);
        pulse_sleep;
        ext_irq <= 1'b1;
        wait_wake;
        ext_irq <= 1'b0;
        chk({30'h0, device_reset_req, took}, 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            wr(`PIFS_OFF_CONTROL, 32'h10);
            pulse_sleep;
            ext_reset_pin_n <= (k != 0);
            brownout_event <= (k == 1);
            power_on_event <= (k == 2);
            wait_wake;
            chk({31'h0, device_reset_req}, 32'h1);
            ext_reset_pin_n <= 1'b1;
            brownout_event <= 1'b0;
            power_on_event <= 1'b0;
            @(posedge aclk);
            chk({31'h0, cpu_clk_en}, 32'h1);
            do_reset;
        end
        print_verdict;
    end
endmodule // pifs_top_bench
